// ### bench/i2cfh_partner.sv
// Behavioural bus partner: a master that sends or fetches bytes and a slave that takes or returns them.
`timescale 1ns/1ps
module i2cfh_partner (
  input wire logic scl_w,
  input wire logic sda_w,
  input wire logic slv,
  output logic scl_lo,
  output logic sda_lo,
  output logic [7:0] got,
  output int got_cnt,
  output int stop_cnt
);
  logic [7:0] sh;
  logic [7:0] rd_b = 8'hff;
  initial
  begin
    scl_lo = 0;
    sda_lo = 0;
    got = '0;
    got_cnt = 0;
    stop_cnt = 0;
  end
  task automatic start();
    sda_lo = 1;
    #62.5;
    scl_lo = 1;
    #31.25;
  endtask
  // The wait on the wire honours the stretching that holds the byte until firmware acts.
  task automatic send(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      sda_lo = ~v[i];
      #31.25;
      scl_lo = 0;
      wait (scl_w);
      #31.25;
      r[i] = sda_w;
      #31.25;
      scl_lo = 1;
      #31.25;
    end
  endtask
  task automatic stop();
    sda_lo = 1;
    #31.25;
    scl_lo = 0;
    #31.25;
    sda_lo = 0;
    #62.5;
  endtask
  always @(posedge sda_w)
  begin
    if (scl_w)
      stop_cnt++;
  end
  always
  begin
    @(negedge sda_w iff scl_w);
    if (slv)
    begin
      repeat (8)
      begin
        @(posedge scl_w);
        sh = {sh[6:0], sda_w};
      end
      @(negedge scl_w);
      sda_lo = 1;
      @(negedge scl_w);
      got = sh;
      got_cnt++;
      // A read address makes the slave return its byte, changing the data line only while the clock is low.
      for (int i = 7; i >= 0 && sh[0]; i--)
      begin
        sda_lo = ~rd_b[i];
        @(negedge scl_w);
      end
      sda_lo = 0;
    end
  end
endmodule

// ### bench/tb_i2c_firmware_handshake_engine.sv
// Self-checking bench of the two-wire controller with firmware handshake.
`timescale 1ns/1ps
module tb_i2c_firmware_handshake_engine;
  logic clk = 0;
  logic resetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, scl_lo, sda_lo, seen;
  logic [8:0] rx9;
  logic slv = 0;
  logic rd_vld = 0;
  i2cfh_pkg::i2cfh_pin_t pin_i, pin_o, pin_oe_n;
  logic [7:0] got;
  int got_cnt, stop_cnt, n;
  int cyc = 0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h00002e9e;
  logic [63:0] q[$];
  logic [63:0] e;
  // Open-drain wires with pull-ups: low when either side pulls.
  assign pin_i.scl = pin_oe_n.scl & ~scl_lo;
  assign pin_i.sda = pin_oe_n.sda & ~sda_lo;
  always #2.5 clk = ~clk;
  i2cfh_top #(.DEPTH(2), .QTR(8)) DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq(irq));
  i2cfh_partner partner (.scl_w(pin_i.scl), .sda_w(pin_i.sda), .slv(slv), .scl_lo(scl_lo), .sda_lo(sda_lo),
    .got(got), .got_cnt(got_cnt), .stop_cnt(stop_cnt));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    cmp_count++;
    if (sn !== ex)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  // A read notes its expected word and mask; the monitor compares at the closing edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
    begin
      q.push_back({m, d & m});
      rd_vld <= 1;
    end
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_vld <= 0;
  endtask
  task automatic wait_irq(input int lim, output logic s);
    s = 0;
    for (int i = 0; i < lim && !s; i++)
    begin
      @(posedge clk);
      s = (irq === 1'b1);
    end
  endtask
  task wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rd_vld && hreadyout === 1'b1)
    begin
      e = q.pop_front();
      chk("hrdata", e[31:0], hrdata & e[63:32]);
    end
  end
  // The ceiling is several times the few thousand cycles the tests need.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    repeat (2) @(posedge clk);
    chk("oe_n", 32'h3, {30'h0, pin_oe_n});
    chk("pin_o", 32'h0, {30'h0, pin_o});
    chk("hresp", 32'h0, {31'h0, hresp});
    resetn <= 1;
    bus(0, i2cfh_pkg::OFF_CTRL, 32'h0, 32'hffffffff);
    bus(0, i2cfh_pkg::OFF_DATA, 32'h0, 32'hffffffff);
    bus(0, 8'h08, 32'h0, 32'hffffffff);
    $display("test reset done");
    // Second pass refuses the byte, so its stop must go unreported.
    for (int k = 1; k >= 0; k--)
    begin
      seed = xs(seed);
      bus(1, i2cfh_pkg::OFF_CTRL, 32'h88, 32'h0);
      fork
        begin
          partner.start();
          partner.send({seed[7:0], 1'b1}, rx9);
        end
        begin
          wait_irq(2000, seen);
          chk("rx irq", 32'h1, {31'h0, seen});
          bus(0, i2cfh_pkg::OFF_CTRL, 32'h110, 32'h111);
          bus(0, i2cfh_pkg::OFF_DATA, {24'h0, seed[7:0]}, 32'hff);
          bus(1, i2cfh_pkg::OFF_CTRL, k ? 32'h89 : 32'h81, 32'h0);
        end
      join
      chk("rx ack", {31'h0, k == 0}, {31'h0, rx9[0]});
      fork
        partner.stop();
        wait_irq(600, seen);
      join
      chk("stop irq", {31'h0, k == 1}, {31'h0, seen});
      if (k == 1)
        bus(0, i2cfh_pkg::OFF_CTRL, 32'h40, 32'h41);
    end
    $display("test slave receive done");
    seed = xs(seed);
    fork
      begin
        partner.start();
        partner.send({seed[15:8], 1'b1}, rx9);
      end
      begin
        wait_irq(2000, seen);
        bus(0, i2cfh_pkg::OFF_DATA, {24'h0, seed[15:8]}, 32'hff);
        bus(1, i2cfh_pkg::OFF_DATA, {24'h0, seed[23:16]}, 32'h0);
        bus(1, i2cfh_pkg::OFF_CTRL, 32'h8b, 32'h0);
      end
    join
    fork
      partner.send(9'h1ff, rx9);
      wait_irq(3000, seen);
    join
    chk("stx irq", 32'h1, {31'h0, seen});
    chk("stx byte", {24'h0, seed[23:16]}, {24'h0, rx9[8:1]});
    bus(0, i2cfh_pkg::OFF_CTRL, 32'h02, 32'h0b);
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h81, 32'h0);
    fork
      partner.stop();
      wait_irq(600, seen);
    join
    chk("stx stop irq", 32'h1, {31'h0, seen});
    $display("test slave transmit done");
    seed = xs(seed);
    slv <= 1;
    bus(1, i2cfh_pkg::OFF_DATA, {24'h0, seed[7:1], 1'b0}, 32'h0);
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h87, 32'h0);
    wait_irq(3000, seen);
    chk("mtx irq", 32'h1, {31'h0, seen});
    bus(0, i2cfh_pkg::OFF_CTRL, 32'h0c, 32'h0d);
    chk("mtx byte", {24'h0, seed[7:1], 1'b0}, {24'h0, got});
    n = stop_cnt;
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h81, 32'h0);
    for (int i = 0; i < 1000 && stop_cnt == n; i++)
      @(posedge clk);
    chk("mtx stop", n + 1, stop_cnt);
    // The busy flag drops only after the stop has passed the input synchroniser.
    repeat (8) @(posedge clk);
    bus(0, i2cfh_pkg::OFF_CTRL, 32'h0, 32'h204);
    $display("test master transmit done");
    partner.rd_b = seed[15:8];
    bus(1, i2cfh_pkg::OFF_DATA, {24'h0, seed[7:1], 1'b1}, 32'h0);
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h87, 32'h0);
    wait_irq(3000, seen);
    chk("mrx addr irq", 32'h1, {31'h0, seen});
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h85, 32'h0);
    wait_irq(3000, seen);
    chk("mrx irq", 32'h1, {31'h0, seen});
    bus(0, i2cfh_pkg::OFF_DATA, {24'h0, seed[15:8]}, 32'hff);
    n = stop_cnt;
    bus(1, i2cfh_pkg::OFF_CTRL, 32'h81, 32'h0);
    for (int i = 0; i < 1000 && stop_cnt == n; i++)
      @(posedge clk);
    chk("mrx stop", n + 1, stop_cnt);
    $display("test master receive done");
    wrap_up();
  end
endmodule

// ### src/i2cfh_pkg.sv
// Shared constants and types of the two-wire firmware handshake controller.
package i2cfh_pkg;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_KHZ = 200000;
  localparam int BUS_KHZ = 100;
  // One quarter of a bus bit period, rounded down.
  localparam int QTR_CYC = CLK_KHZ / (4 * BUS_KHZ);
  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] TX_RST = 8'h00;
  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic enable;
    logic stop_seen;
    logic arb_loss;
    logic first_byte;
    logic ack;
    logic role;
    logic xmit;
    logic proceed;
  } i2cfh_ctrl_t;
  localparam i2cfh_ctrl_t CTRL_RST = '0;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cfh_pin_t;
  typedef enum logic [2:0] {EV_SRX, EV_STOP, EV_STX, EV_MTX, EV_MRX, EV_ARB} i2cfh_ev_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S_BIT, ST_S_ACK, ST_PUSH, ST_HOLD, ST_M_START, ST_M_BIT, ST_M_STOP, ST_M_ARB
  } i2cfh_st_t;
endpackage

// ### src/i2cfh_top.sv
// Two-wire bus controller with firmware handshake per byte, reached over AHB-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Interrupt rises only once every status bit has taken its new value.
// RQ2: Slave receive interrupts per byte; first byte after start sets first flag.
// RQ3: Firmware services data, then sets ack, direction and proceed.
// RQ4: Slave receive interrupts on stop and sets stop-seen flag.
// RQ5: After a not-acknowledged received byte the following stop is ignored.
// RQ6: Slave transmit interrupts per byte; ack bit shows master's acknowledge.
// RQ7: Firmware loads next byte, then sets direction and proceed.
// RQ8: Master transmit interrupts per byte; firmware sets direction, role, proceed.
// RQ9: Clearing role after master transmit sends stop and returns idle.
// RQ10: Master receive interrupts per byte; firmware reads data, sets ack, proceed.
// RQ11: Role cleared with proceed after master receive sends stop, goes idle.
// RQ12: Lost arbitration clears role, sets loss flag, interrupts at next stop.
// RQ13: Proceed is cleared by hardware before each byte or stop interrupt.
// RQ14: Firmware sets proceed after servicing data and other control bits.
// RQ15: Firmware writes control once with proceed, without polling it first.
// RQ16: While proceed is set the block is busy and may change registers.
// RQ17: Firmware reads status, services data, writes control to continue.
// RQ18: Interrupt is meant for the lowest-priority processor vector.
// RQ19: Start, repeated start, stop and acknowledge on the bus; MSB first.
module i2cfh_top #(
  parameter int DEPTH = 2,
  parameter int QTR = i2cfh_pkg::QTR_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire i2cfh_pkg::i2cfh_pin_t pin_i,
  output i2cfh_pkg::i2cfh_pin_t pin_o,
  output i2cfh_pkg::i2cfh_pin_t pin_oe_n,
  output logic irq
);
  localparam int QW = (QTR > 1) ? $clog2(QTR) : 1;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [QW-1:0] QLAST = QW'(QTR - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || QTR < 2)
  begin : g_chk
    $error("DEPTH must be a power of two of at least 2 and QTR at least 2");
  end
  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  i2cfh_pkg::i2cfh_pin_t s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
  logic scl_rise, scl_fall, start_det, stop_det, bus_busy_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      filt_reg <= '1;
      prev_reg <= '1;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg.scl == s3_reg.scl)
        filt_reg.scl <= s3_reg.scl;
      if (s2_reg.sda == s3_reg.sda)
        filt_reg.sda <= s3_reg.sda;
      prev_reg <= filt_reg;
    end
  end
  assign scl_rise = filt_reg.scl & ~prev_reg.scl;
  assign scl_fall = ~filt_reg.scl & prev_reg.scl;
  assign start_det = filt_reg.scl & prev_reg.scl & prev_reg.sda & ~filt_reg.sda; // RQ19
  assign stop_det = filt_reg.scl & prev_reg.scl & ~prev_reg.sda & filt_reg.sda; // RQ19
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_busy_reg <= 1'b0;
    else if (start_det)
      bus_busy_reg <= 1'b1;
    else if (stop_det)
      bus_busy_reg <= 1'b0;
  end
  // ***************************************************************
  // Receive buffer
  // ***************************************************************
  logic [7:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg, rptr_reg;
  logic [AW:0] cnt_reg;
  logic push, pop, in_ready, out_valid;
  logic [7:0] shreg_reg;
  i2cfh_pkg::i2cfh_st_t st_reg;
  logic dir_reg;
  assign in_ready = cnt_reg < FULL;
  assign out_valid = cnt_reg != '0;
  // The engine keeps the clock stretched while the buffer is full, so no word is lost.
  assign push = (st_reg == i2cfh_pkg::ST_PUSH) & ~dir_reg & in_ready;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wptr_reg] <= shreg_reg;
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
  // ***************************************************************
  // Bus engine
  // ***************************************************************
  i2cfh_pkg::i2cfh_ctrl_t ctrl_reg;
  logic [7:0] tx_reg;
  i2cfh_pkg::i2cfh_ev_t ev_kind_reg;
  logic [3:0] bitcnt_reg;
  logic [1:0] phase_reg;
  logic [QW-1:0] qcnt_reg;
  logic scl_drv_reg, sda_drv_reg, mst_reg, sact_reg, no_stop_reg, first_pend_reg;
  logic ev_reg, first_out_reg, ack_smp_reg, arb_reg, irq_reg;
  logic qrun, qtick, is_slave, wl;
  assign qrun = (st_reg == i2cfh_pkg::ST_M_START || st_reg == i2cfh_pkg::ST_M_BIT || st_reg == i2cfh_pkg::ST_M_STOP)
    && !(st_reg == i2cfh_pkg::ST_M_BIT && phase_reg == 2'd2 && !filt_reg.scl);
  assign qtick = qrun && qcnt_reg == QLAST;
  assign is_slave = st_reg == i2cfh_pkg::ST_IDLE || st_reg == i2cfh_pkg::ST_S_BIT || st_reg == i2cfh_pkg::ST_S_ACK;
  // Wanted data line level of the current master bit.
  assign wl = (bitcnt_reg < 4'd8) ? (dir_reg ? shreg_reg[7] : 1'b1) : (dir_reg | ~ctrl_reg.ack);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      qcnt_reg <= '0;
    else if (!qrun || qtick)
      qcnt_reg <= '0;
    else
      qcnt_reg <= qcnt_reg + 1'b1;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= i2cfh_pkg::ST_IDLE;
      shreg_reg <= 8'h00;
      bitcnt_reg <= 4'h0;
      phase_reg <= 2'h0;
      dir_reg <= 1'b0;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      mst_reg <= 1'b0;
      sact_reg <= 1'b0;
      no_stop_reg <= 1'b0;
      first_pend_reg <= 1'b0;
      ev_reg <= 1'b0;
      ev_kind_reg <= i2cfh_pkg::EV_SRX;
      first_out_reg <= 1'b0;
      ack_smp_reg <= 1'b0;
      arb_reg <= 1'b0;
    end
    else
    begin
      ev_reg <= 1'b0;
      arb_reg <= 1'b0;
      if (qtick)
        phase_reg <= phase_reg + 1'b1;
      case (st_reg)
        i2cfh_pkg::ST_IDLE:
        begin
          scl_drv_reg <= 1'b0;
          if (ctrl_reg.enable & ctrl_reg.role & ctrl_reg.proceed & ~ev_reg & ~bus_busy_reg)
          begin
            dir_reg <= ctrl_reg.xmit;
            shreg_reg <= tx_reg;
            mst_reg <= 1'b1;
            phase_reg <= 2'h0;
            st_reg <= i2cfh_pkg::ST_M_START;
          end
        end
        i2cfh_pkg::ST_S_BIT:
        begin
          if (scl_rise)
          begin
            bitcnt_reg <= bitcnt_reg + 1'b1;
            if (bitcnt_reg < 4'd8 && !dir_reg)
              shreg_reg <= {shreg_reg[6:0], filt_reg.sda}; // RQ19
            if (bitcnt_reg == 4'd8)
              ack_smp_reg <= ~filt_reg.sda; // RQ6
          end
          if (scl_fall && !dir_reg && bitcnt_reg == 4'd8)
            st_reg <= i2cfh_pkg::ST_PUSH; // RQ2
          else if (scl_fall && dir_reg)
          begin
            if (bitcnt_reg < 4'd8)
            begin
              shreg_reg <= {shreg_reg[6:0], 1'b0};
              sda_drv_reg <= ~shreg_reg[6]; // RQ19
            end
            else if (bitcnt_reg == 4'd8)
              sda_drv_reg <= 1'b0;
            else if (bitcnt_reg == 4'd9)
              st_reg <= i2cfh_pkg::ST_PUSH; // RQ6
          end
        end
        i2cfh_pkg::ST_S_ACK:
        begin
          if (scl_fall)
          begin
            sda_drv_reg <= 1'b0;
            bitcnt_reg <= 4'h0;
            dir_reg <= ctrl_reg.xmit;
            st_reg <= i2cfh_pkg::ST_S_BIT;
            if (!ctrl_reg.ack)
            begin
              no_stop_reg <= 1'b1; // RQ5
              st_reg <= i2cfh_pkg::ST_IDLE;
            end
            else if (ctrl_reg.xmit)
            begin
              shreg_reg <= tx_reg;
              sda_drv_reg <= ~tx_reg[7];
            end
          end
        end
        i2cfh_pkg::ST_PUSH:
        begin
          scl_drv_reg <= 1'b1;
          if (dir_reg || in_ready)
          begin
            ev_reg <= 1'b1; // RQ2 RQ6 RQ8 RQ10
            ev_kind_reg <= mst_reg ? (dir_reg ? i2cfh_pkg::EV_MTX : i2cfh_pkg::EV_MRX)
              : (dir_reg ? i2cfh_pkg::EV_STX : i2cfh_pkg::EV_SRX);
            first_out_reg <= first_pend_reg & ~mst_reg; // RQ2
            first_pend_reg <= 1'b0;
            st_reg <= i2cfh_pkg::ST_HOLD;
          end
        end
        i2cfh_pkg::ST_HOLD:
        begin
          // The proceed bit is cleared one edge after the event, so it is ignored while the event stands.
          if (ctrl_reg.proceed && !ev_reg)
          begin
            bitcnt_reg <= 4'h0;
            phase_reg <= 2'h0;
            if (mst_reg && !ctrl_reg.role)
              st_reg <= i2cfh_pkg::ST_M_STOP; // RQ9 RQ11
            else if (mst_reg)
            begin
              dir_reg <= ctrl_reg.xmit; // RQ8 RQ10
              shreg_reg <= tx_reg;
              st_reg <= i2cfh_pkg::ST_M_BIT;
            end
            else if (dir_reg && ctrl_reg.xmit)
            begin
              shreg_reg <= tx_reg;
              sda_drv_reg <= ~tx_reg[7];
              scl_drv_reg <= 1'b0;
              st_reg <= i2cfh_pkg::ST_S_BIT;
            end
            else if (dir_reg)
            begin
              scl_drv_reg <= 1'b0;
              st_reg <= i2cfh_pkg::ST_IDLE;
            end
            else
            begin
              sda_drv_reg <= ctrl_reg.ack;
              scl_drv_reg <= 1'b0;
              st_reg <= i2cfh_pkg::ST_S_ACK;
            end
          end
        end
        i2cfh_pkg::ST_M_START:
        begin
          sda_drv_reg <= 1'b1; // RQ19
          if (qtick && phase_reg == 2'd1)
          begin
            phase_reg <= 2'h0;
            bitcnt_reg <= 4'h0;
            st_reg <= i2cfh_pkg::ST_M_BIT;
          end
        end
        i2cfh_pkg::ST_M_BIT:
        begin
          if (phase_reg == 2'd0)
            scl_drv_reg <= 1'b1;
          if (phase_reg == 2'd1)
            sda_drv_reg <= ~wl; // RQ19
          if (phase_reg == 2'd2)
            scl_drv_reg <= 1'b0;
          if (qtick && phase_reg == 2'd3)
          begin
            bitcnt_reg <= bitcnt_reg + 1'b1;
            if (bitcnt_reg < 4'd8)
              shreg_reg <= {shreg_reg[6:0], filt_reg.sda};
            else
            begin
              ack_smp_reg <= ~filt_reg.sda;
              st_reg <= i2cfh_pkg::ST_PUSH;
            end
            if (dir_reg && bitcnt_reg < 4'd8 && wl && !filt_reg.sda)
            begin
              arb_reg <= 1'b1; // RQ12
              scl_drv_reg <= 1'b0;
              sda_drv_reg <= 1'b0;
              st_reg <= i2cfh_pkg::ST_M_ARB;
            end
          end
        end
        i2cfh_pkg::ST_M_STOP:
        begin
          scl_drv_reg <= phase_reg == 2'd0 || phase_reg == 2'd1; // RQ9 RQ11
          sda_drv_reg <= phase_reg != 2'd3;
          if (qtick && phase_reg == 2'd3)
          begin
            mst_reg <= 1'b0;
            st_reg <= i2cfh_pkg::ST_IDLE;
          end
        end
        i2cfh_pkg::ST_M_ARB:
        begin
          if (stop_det)
          begin
            ev_reg <= 1'b1; // RQ12
            ev_kind_reg <= i2cfh_pkg::EV_ARB;
            mst_reg <= 1'b0;
            st_reg <= i2cfh_pkg::ST_IDLE;
          end
        end
        default:
          st_reg <= i2cfh_pkg::ST_IDLE;
      endcase
      if (is_slave && stop_det && sact_reg)
      begin
        sact_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
        st_reg <= i2cfh_pkg::ST_IDLE;
        if (!no_stop_reg)
        begin
          ev_reg <= 1'b1; // RQ4 RQ5
          ev_kind_reg <= i2cfh_pkg::EV_STOP;
        end
      end
      else if (is_slave && start_det && ctrl_reg.enable && !ctrl_reg.role)
      begin
        sact_reg <= 1'b1;
        no_stop_reg <= 1'b0;
        first_pend_reg <= 1'b1; // RQ2
        dir_reg <= 1'b0;
        bitcnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
        st_reg <= i2cfh_pkg::ST_S_BIT;
      end
    end
  end
  assign pin_o = '0;
  assign pin_oe_n = '{scl: ~scl_drv_reg, sda: ~sda_drv_reg};
  // ***************************************************************
  // Registers and AHB-Lite slave
  // ***************************************************************
  logic ap, wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  assign ap = hsel & hready & htrans[1];
  assign pop = ap & ~hwrite & (haddr[7:0] == i2cfh_pkg::OFF_DATA) & out_valid;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= ap & hwrite;
      wr_addr_reg <= haddr[7:0];
      if (ap && !hwrite)
      begin
        if (haddr[7:0] == i2cfh_pkg::OFF_CTRL)
          hrdata_reg <= {22'h0, bus_busy_reg, out_valid, ctrl_reg}; // RQ16
        else if (haddr[7:0] == i2cfh_pkg::OFF_DATA && out_valid)
          hrdata_reg <= {24'h0, mem_reg[rptr_reg]};
        else
          hrdata_reg <= 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= i2cfh_pkg::CTRL_RST;
      tx_reg <= i2cfh_pkg::TX_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_pend_reg && wr_addr_reg == i2cfh_pkg::OFF_CTRL)
        ctrl_reg <= hwdata[7:0];
      if (wr_pend_reg && wr_addr_reg == i2cfh_pkg::OFF_DATA)
        tx_reg <= hwdata[7:0];
      // Hardware updates come last so an event beats a simultaneous software write.
      if (arb_reg)
      begin
        ctrl_reg.role <= 1'b0; // RQ12
        ctrl_reg.arb_loss <= 1'b1;
      end
      if (ev_reg)
      begin
        ctrl_reg.proceed <= 1'b0; // RQ13
        if (ev_kind_reg == i2cfh_pkg::EV_SRX && first_out_reg)
          ctrl_reg.first_byte <= 1'b1; // RQ2
        if (ev_kind_reg == i2cfh_pkg::EV_STOP)
          ctrl_reg.stop_seen <= 1'b1; // RQ4
        if (ev_kind_reg == i2cfh_pkg::EV_STX || ev_kind_reg == i2cfh_pkg::EV_MTX)
          ctrl_reg.ack <= ack_smp_reg; // RQ6
      end
      irq_reg <= ev_reg; // RQ1 RQ18
    end
  end
  assign irq = irq_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_settle;
    ev_reg && ev_kind_reg != i2cfh_pkg::EV_STOP && ev_kind_reg != i2cfh_pkg::EV_ARB
      |=> irq_reg && st_reg == i2cfh_pkg::ST_HOLD && !ctrl_reg.proceed;
  endproperty
  a_settle: assert property (p_settle) else $error("interrupt before status settled"); // RQ1
  property p_clr;
    ev_reg |=> !ctrl_reg.proceed;
  endproperty
  a_clr: assert property (p_clr) else $error("proceed not cleared at event"); // RQ13
  property p_first;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_SRX && first_out_reg |=> ctrl_reg.first_byte;
  endproperty
  a_first: assert property (p_first) else $error("first byte flag missing"); // RQ2
  property p_stop;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_STOP |=> ctrl_reg.stop_seen && irq_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag missing"); // RQ4
  property p_nostop;
    stop_det && no_stop_reg && st_reg == i2cfh_pkg::ST_IDLE |=> !ev_reg;
  endproperty
  a_nostop: assert property (p_nostop) else $error("stop reported after nack"); // RQ5
  property p_ack;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_STX |=> ctrl_reg.ack == $past(ack_smp_reg);
  endproperty
  a_ack: assert property (p_ack) else $error("ack bit wrong after transmit"); // RQ6
  property p_mtx;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_MTX |-> st_reg == i2cfh_pkg::ST_HOLD ##1 irq_reg;
  endproperty
  a_mtx: assert property (p_mtx) else $error("master transmit event wrong"); // RQ8
  property p_stopgen;
    st_reg == i2cfh_pkg::ST_HOLD && mst_reg && ctrl_reg.proceed && !ctrl_reg.role && !ev_reg
      |=> st_reg == i2cfh_pkg::ST_M_STOP ##1 sda_drv_reg;
  endproperty
  a_stopgen: assert property (p_stopgen) else $error("stop not generated"); // RQ9
  property p_arb;
    arb_reg |=> !ctrl_reg.role && ctrl_reg.arb_loss && st_reg == i2cfh_pkg::ST_M_ARB && !irq_reg;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss not recorded"); // RQ12
  property p_arbw;
    st_reg == i2cfh_pkg::ST_M_ARB && !stop_det |=> !ev_reg;
  endproperty
  a_arbw: assert property (p_arbw) else $error("arbitration interrupt before stop"); // RQ12
  property p_msb;
    st_reg == i2cfh_pkg::ST_M_BIT && phase_reg == 2'd2 && dir_reg && bitcnt_reg < 4'd8
      |-> sda_drv_reg == !shreg_reg[7];
  endproperty
  a_msb: assert property (p_msb) else $error("master bit order wrong"); // RQ19
  property p_c_srx;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_SRX;
  endproperty
  c_srx: cover property (p_c_srx);
  property p_c_mrx;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_MRX;
  endproperty
  c_mrx: cover property (p_c_mrx);
  property p_c_stop;
    ev_reg && ev_kind_reg == i2cfh_pkg::EV_STOP;
  endproperty
  c_stop: cover property (p_c_stop);
endmodule
